// File: tb_wdog.sv
// Purpose: self-checking bench of the watchdog through its register port
// Assumes: short intervals stand in for the long ones, window stays 512
// Notes: timeout figures are checked with a few cycles of slack
`timescale 1ns/100ps
`default_nettype none
`include "wdog_params.svh"
module tb;
    localparam int N0 = 1024;
    localparam logic [7:0] A_CK = `WDOG_ADDR_CLOCK_CONTROL;
    localparam logic [7:0] A_CTL = `WDOG_ADDR_CONTROL;
    localparam logic [7:0] A_KEY = `WDOG_ADDR_KEY;
    localparam logic [7:0] A_IE = `WDOG_ADDR_IRQ_ENABLE;
    localparam logic [7:0] A_IP = `WDOG_ADDR_IRQ_PRIORITY;
    logic i_clk;
    logic i_rst;
    logic i_global_irq_enable;
    wire logic sfr_wr;
    wire logic [7:0] sfr_addr;
    wire logic [7:0] sfr_wdata;
    wire logic [7:0] sfr_rdata;
    wire logic sfr_hit;
    wire logic wdog_irq;
    wire logic irq_prio;
    wire logic mcu_reset;
    logic [7:0] rd;
    int miscompares = 0;
    int num_checks = 0;
    int cyc = 0;
    int rst_cnt = 0;
    int rst_at = 0;
    int iv [4] = '{N0, 2048, 4096, 8192};
    int t0;
    int k;
    wdog_timer #(.P_INTERVAL_0(N0), .P_INTERVAL_1(2048), .P_INTERVAL_2(4096),
        .P_INTERVAL_3(8192)) uut (.i_clk(i_clk), .i_rst(i_rst), .i_sfr_wr(sfr_wr),
        .i_sfr_addr(sfr_addr), .i_sfr_wdata(sfr_wdata), .o_sfr_rdata(sfr_rdata),
        .o_sfr_hit(sfr_hit), .i_global_irq_enable(i_global_irq_enable),
        .o_wdog_irq(wdog_irq), .o_wdog_irq_priority(irq_prio), .o_mcu_reset(mcu_reset));
    wdog_cpu_model u_cpu (.i_clk(i_clk), .i_sfr_rdata(sfr_rdata), .o_sfr_wr(sfr_wr),
        .o_sfr_addr(sfr_addr), .o_sfr_wdata(sfr_wdata));
    initial begin
        i_clk = 1'b0;
        forever #50 i_clk = ~i_clk;
    end
    always @(posedge i_clk) begin
        cyc <= cyc + 1;
        if (mcu_reset === 1'b1) begin
            rst_cnt <= rst_cnt + 1;
            rst_at <= cyc;
        end
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask : check
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        u_cpu.get(a, rd);
        check(rd, exp);
    endtask : rd_chk
    task automatic wait_to(input int t);
        while (cyc < t) begin
            @(posedge i_clk);
            #10;
        end
    endtask : wait_to
    // three writes back to back, then the strobe drops
    task automatic seq3(input logic [7:0] a0, d0, a1, d1, a2, d2);
        u_cpu.put(a0, d0);
        u_cpu.put(a1, d1);
        u_cpu.put(a2, d2);
        u_cpu.idle();
    endtask : seq3
    task automatic stop_test();
        if (miscompares == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : stop_test
    // the whole sequence needs about 20000 cycles
    initial begin
        #6000000;
        miscompares++;
        stop_test();
    end
    initial begin
        i_rst = 1'b1;
        i_global_irq_enable = 1'b1;
        repeat (5) @(posedge i_clk);
        #10;
        i_rst = 1'b0;
        check({sfr_hit, wdog_irq, irq_prio, mcu_reset}, 4'h0);
        rd_chk(A_CK, 8'h03);
        check(sfr_hit, 1'b1);
        rd_chk(A_CTL, 8'h00);
        rd_chk(A_IE, 8'h00);
        rd_chk(A_IP, 8'h00);
        rd_chk(A_KEY, 8'h00);
        check(sfr_hit, 1'b0);
        rd_chk(8'h01, 8'h00);
        check(sfr_hit, 1'b0);
        // unkeyed, broken and consumed keys must all be refused
        seq3(A_CK, 8'h03, A_IE, 8'h00, A_CTL, 8'h02);
        rd_chk(A_CTL, 8'h00);
        seq3(A_KEY, 8'hAA, A_CK, 8'h03, A_KEY, 8'h55);
        seq3(A_KEY, 8'h55, A_CTL, 8'h02, A_IE, 8'h00);
        rd_chk(A_CTL, 8'h00);
        seq3(A_KEY, 8'hAA, A_KEY, 8'h55, A_CK, 8'h03);
        seq3(A_CTL, 8'h02, A_IE, 8'h00, A_IE, 8'h00);
        rd_chk(A_CTL, 8'h00);
        u_cpu.ctl_put(8'h03);
        rd_chk(A_CTL, 8'h02);
        u_cpu.ctl_put(8'h00);
        seq3(A_IP, 8'h10, A_IP, 8'h10, A_IP, 8'h10);
        check(irq_prio, 1'b1);
        rd_chk(A_IP, 8'h10);
        seq3(A_IP, 8'h00, A_IE, 8'h10, A_IE, 8'h10);
        check(irq_prio, 1'b0);
        for (k = 0; k < 4; k++) begin
            seq3(A_CK, {k[1:0], 6'h03}, A_IE, 8'h10, A_IE, 8'h10);
            rd_chk(A_CK, {k[1:0], 6'h03});
            u_cpu.ctl_put(8'h01);
            t0 = cyc;
            wait_to(t0 + iv[k] - 4);
            check(wdog_irq, 1'b0);
            wait_to(t0 + iv[k] + 4);
            check(wdog_irq, 1'b1);
            rd_chk(A_CTL, 8'h08);
        end
        check(rst_cnt, 0);
        seq3(A_CK, 8'h03, A_IE, 8'h00, A_IE, 8'h00);
        u_cpu.ctl_put(8'h01);
        t0 = cyc;
        wait_to(t0 + N0 + 4);
        check(wdog_irq, 1'b0);
        rd_chk(A_CTL, 8'h08);
        seq3(A_IE, 8'h10, A_IE, 8'h10, A_IE, 8'h10);
        i_global_irq_enable = 1'b0;
        wait_to(cyc + 3);
        check(wdog_irq, 1'b0);
        i_global_irq_enable = 1'b1;
        wait_to(cyc + 3);
        check(wdog_irq, 1'b1);
        u_cpu.ctl_put(8'h00);
        wait_to(cyc + 3);
        check(wdog_irq, 1'b0);
        u_cpu.ctl_put(8'h08);
        wait_to(cyc + 3);
        check(wdog_irq, 1'b1);
        // reset enabled: interrupt first, reset one window later
        u_cpu.ctl_put(8'h03);
        t0 = cyc;
        wait_to(t0 + N0 + 4);
        check(wdog_irq, 1'b1);
        check(rst_cnt, 0);
        wait_to(t0 + N0 + 520);
        check(rst_cnt, 1);
        check((rst_at - t0 >= N0 + 508) && (rst_at - t0 <= N0 + 516), 1'b1);
        rd_chk(A_CTL, 8'h06);
        t0 = rst_at;
        wait_to(t0 + N0 - 4);
        check(wdog_irq, 1'b0);
        wait_to(t0 + N0 + 6);
        check(wdog_irq, 1'b1);
        // restart in mid-window cancels the pending reset
        wait_to(t0 + N0 + 200);
        u_cpu.ctl_put(8'h03);
        wait_to(cyc + 600);
        check(rst_cnt, 1);
        rd_chk(A_CTL, 8'h02);
        u_cpu.ctl_put(8'h04);
        wait_to(cyc + 10);
        check(rst_cnt, 1);
        rd_chk(A_CTL, 8'h04);
        stop_test();
    end
endmodule : tb
`default_nettype wire

// File: wdog_counter.sv
// Purpose: interval counter and pre-reset window counter
// Assumes: restart is a one-cycle strobe
// Notes: expire is combinational, one cycle per interval
`timescale 1ns/100ps
`default_nettype none
`include "wdog_params.svh"
module wdog_counter #(
    parameter int P_INTERVAL_0 = `WDOG_INTERVAL_0,
    parameter int P_INTERVAL_1 = `WDOG_INTERVAL_1,
    parameter int P_INTERVAL_2 = `WDOG_INTERVAL_2,
    parameter int P_INTERVAL_3 = `WDOG_INTERVAL_3
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // link to top
    wdog_link_if.cnt lnk
);
    localparam logic [8:0] WIN_LAST = 9'(`WDOG_WINDOW_CLOCKS - 1);
    logic [25:0] cnt;
    logic [25:0] term;
    logic win_act;
    logic [8:0] win_cnt;

    always_comb begin
        unique case (lnk.interval)
            2'b00: term = 26'(P_INTERVAL_0 - 1);
            2'b01: term = 26'(P_INTERVAL_1 - 1);
            2'b10: term = 26'(P_INTERVAL_2 - 1);
            2'b11: term = 26'(P_INTERVAL_3 - 1);
        endcase
    end

    // >= so that shrinking the interval mid-count still expires at once
    assign lnk.expire = !lnk.restart && (cnt >= term);
    assign lnk.fire = win_act && (win_cnt == WIN_LAST) && !lnk.restart;

    // every main clock edge counts, no prescaler
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            cnt <= 26'h0000000;
        end else if (lnk.restart || lnk.expire) begin
            cnt <= 26'h0000000;
        end else begin
            cnt <= cnt + 26'h0000001;
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            win_act <= 1'b0;
            win_cnt <= 9'h000;
        end else if (lnk.restart) begin
            win_act <= 1'b0;
            win_cnt <= 9'h000;
        end else if (lnk.expire) begin
            win_act <= 1'b1;
            win_cnt <= 9'h000;
        end else if (win_act) begin
            win_cnt <= win_cnt + 9'h001;
            if (win_cnt == WIN_LAST) begin
                win_act <= 1'b0;
            end
        end
    end

    a_restart_zero: assert property (@(posedge i_clk) disable iff (i_rst)
        lnk.restart |=> (cnt == 26'h0000000) && !win_act)
        else $error("restart did not clear the counts");
    a_window_timing: assert property (@(posedge i_clk) disable iff (i_rst)
        lnk.fire |-> $past(lnk.expire, 512))
        else $error("window end not 512 clocks after expiry");
endmodule : wdog_counter
`default_nettype wire

// File: wdog_cpu_model.sv
// Purpose: CPU core model driving the special function register port
// Assumes: all changes land a fixed delay after the rising edge
// Notes: write data lines carry changing junk while no write is made
`timescale 1ns/100ps
`default_nettype none
`include "wdog_params.svh"
module wdog_cpu_model (
    // clock
    input wire logic i_clk,
    // register port
    input wire logic [7:0] i_sfr_rdata,
    output logic o_sfr_wr,
    output logic [7:0] o_sfr_addr,
    output logic [7:0] o_sfr_wdata
);
    localparam int DLY = 10;
    initial begin
        o_sfr_wr = 1'b0;
        o_sfr_addr = 8'h00;
        o_sfr_wdata = 8'h00;
    end
    // strobe stays up until idle or get, so consecutive puts run back to back
    task automatic put(input logic [7:0] addr, input logic [7:0] data);
        @(posedge i_clk);
        #DLY;
        o_sfr_wr = 1'b1;
        o_sfr_addr = addr;
        o_sfr_wdata = data;
    endtask : put
    task automatic idle();
        @(posedge i_clk);
        #DLY;
        o_sfr_wr = 1'b0;
        o_sfr_wdata = ~o_sfr_wdata;
    endtask : idle
    // read data is registered, so it is taken one edge after the address
    task automatic get(input logic [7:0] addr, output logic [7:0] data);
        @(posedge i_clk);
        #DLY;
        o_sfr_wr = 1'b0;
        o_sfr_addr = addr;
        o_sfr_wdata = ~o_sfr_wdata;
        @(posedge i_clk);
        #DLY;
        data = i_sfr_rdata;
    endtask : get
    // a fresh key before every control write, never reused
    task automatic ctl_put(input logic [7:0] data);
        put(`WDOG_ADDR_KEY, `WDOG_KEY_FIRST);
        put(`WDOG_ADDR_KEY, `WDOG_KEY_SECOND);
        put(`WDOG_ADDR_CONTROL, data);
        idle();
    endtask : ctl_put
endmodule : wdog_cpu_model
`default_nettype wire

// File: wdog_link_if.sv
// Purpose: signals between the watchdog top and its counter and unlock parts
// Assumes: single clock domain
// Notes: none
`timescale 1ns/100ps
`default_nettype none
interface wdog_link_if;
    logic restart;
    logic [1:0] interval;
    logic expire;
    logic fire;
    logic sfr_we;
    logic [7:0] sfr_addr;
    logic [7:0] sfr_wdata;
    logic unlocked;
    modport main (output restart, interval, sfr_we, sfr_addr, sfr_wdata,
                  input expire, fire, unlocked);
    modport cnt (input restart, interval, output expire, fire);
    modport key (input sfr_we, sfr_addr, sfr_wdata, output unlocked);
endinterface : wdog_link_if
`default_nettype wire

// File: wdog_params.svh
// Purpose: addresses, bit positions, reset values and counts of the watchdog
// Assumes: included by bare name, definitions only
// Notes: interval figures are clock counts of the main clock
`ifndef WDOG_PARAMS_SVH
`define WDOG_PARAMS_SVH
`define WDOG_ADDR_CLOCK_CONTROL 8'h8E
`define WDOG_ADDR_KEY 8'hC7
`define WDOG_ADDR_CONTROL 8'hD8
`define WDOG_ADDR_IRQ_ENABLE 8'hE8
`define WDOG_ADDR_IRQ_PRIORITY 8'hF8
`define WDOG_KEY_FIRST 8'hAA
`define WDOG_KEY_SECOND 8'h55
`define WDOG_CLKCTL_RESET 8'h03
`define WDOG_BIT_RESTART 0
`define WDOG_BIT_RESET_EN 1
`define WDOG_BIT_CAUSE 2
`define WDOG_BIT_FLAG 3
`define WDOG_BIT_IRQ_EN 4
`define WDOG_BIT_PRIO 4
`define WDOG_INTERVAL_0 131072
`define WDOG_INTERVAL_1 1048576
`define WDOG_INTERVAL_2 8388608
`define WDOG_INTERVAL_3 67108864
`define WDOG_WINDOW_CLOCKS 512
`endif

// File: wdog_pkg.sv
// Purpose: shared types of the watchdog
// Assumes: nothing
// Notes: unlock sequencer states
`default_nettype none
package wdog_pkg;
    typedef enum logic [1:0] {
        WDOG_KEY_IDLE = 2'b00,
        WDOG_KEY_HALF = 2'b01,
        WDOG_KEY_OPEN = 2'b10
    } wdog_key_t;
endpackage : wdog_pkg
`default_nettype wire

// File: wdog_timer.sv
// Purpose: watchdog timer with special function registers and reset output
// Assumes: one write strobe per cycle from the CPU core; global enable is a level
// Notes: read data is registered, one cycle after the address is presented
//
// How it works
// - counter advances on every main clock edge, no prescaler.
// - interval field codes select 131072, 1048576, 8388608 or 67108864 clocks.
// - with reset enabled, MCU reset follows expiry by 512 clocks unless restarted.
// - writing one to restart bit zeroes the interval and window counts.
// - control bit 1 chooses whether a timeout resets the MCU.
// - reset enable alters the flag only in that a watchdog reset clears it, ending the request.
// - a watchdog reset restarts the count from zero and keeps running.
// - cause flag set by watchdog reset, cleared by software, write one harmless.
// - flag without interrupt enable only reports, no interrupt raised.
// - flag with enable raises interrupt; reset still follows 512 clocks later.
// - interrupt priority comes from bit 4 of extended priority register.
// - control write takes effect only right after key writes AA then 55.
// - unused control bits 7 to 4 carry no meaning; here they read zero.
// - interval lives in clock control bits 7:6, register resets to 03.
// - restart bit clears itself right after software sets it.
// - expiry sets flag; request needs watchdog enable and global enable.
// - software setting the flag requests an interrupt like a timeout.
`timescale 1ns/100ps
`default_nettype none
`include "wdog_params.svh"
module wdog_timer #(
    parameter int P_INTERVAL_0 = `WDOG_INTERVAL_0,
    parameter int P_INTERVAL_1 = `WDOG_INTERVAL_1,
    parameter int P_INTERVAL_2 = `WDOG_INTERVAL_2,
    parameter int P_INTERVAL_3 = `WDOG_INTERVAL_3
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // special function register port
    input wire logic i_sfr_wr,
    input wire logic [7:0] i_sfr_addr,
    input wire logic [7:0] i_sfr_wdata,
    output logic [7:0] o_sfr_rdata,
    output logic o_sfr_hit,
    // interrupt controller side
    input wire logic i_global_irq_enable,
    output logic o_wdog_irq,
    output logic o_wdog_irq_priority,
    // system reset request
    output logic o_mcu_reset
);
    localparam logic [7:0] CLKCTL_RST = `WDOG_CLKCTL_RESET;

    wdog_link_if lnk ();

    logic [1:0] interval_select;
    logic [2:0] clock_mode;
    logic reset_enable;
    logic reset_cause_flag;
    logic timeout_irq_flag;
    logic wdog_irq_enable;
    logic wdog_irq_priority;
    logic count_restart;
    logic ctl_we;
    logic clkctl_we;
    logic irq_en_we;
    logic irq_prio_we;
    logic [7:0] next_rdata;
    logic next_hit;

    assign lnk.sfr_we = i_sfr_wr;
    assign lnk.sfr_addr = i_sfr_addr;
    assign lnk.sfr_wdata = i_sfr_wdata;
    assign lnk.interval = interval_select;
    // our own reset request restarts the count, the watchdog is never stopped
    assign lnk.restart = count_restart || o_mcu_reset;

    assign ctl_we = i_sfr_wr && (i_sfr_addr == `WDOG_ADDR_CONTROL) && lnk.unlocked;
    assign clkctl_we = i_sfr_wr && (i_sfr_addr == `WDOG_ADDR_CLOCK_CONTROL);
    assign irq_en_we = i_sfr_wr && (i_sfr_addr == `WDOG_ADDR_IRQ_ENABLE);
    assign irq_prio_we = i_sfr_wr && (i_sfr_addr == `WDOG_ADDR_IRQ_PRIORITY);
    assign o_wdog_irq_priority = wdog_irq_priority;

    wdog_counter #(
        .P_INTERVAL_0(P_INTERVAL_0),
        .P_INTERVAL_1(P_INTERVAL_1),
        .P_INTERVAL_2(P_INTERVAL_2),
        .P_INTERVAL_3(P_INTERVAL_3)
    ) u_counter (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .lnk(lnk.cnt)
    );

    wdog_unlock u_unlock (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .lnk(lnk.key)
    );

    // clock control: interval plus the memory mode bits kept for read-back
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            interval_select <= CLKCTL_RST[7:6];
            clock_mode <= CLKCTL_RST[2:0];
        end else if (clkctl_we) begin
            interval_select <= i_sfr_wdata[7:6];
            clock_mode <= i_sfr_wdata[2:0];
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            wdog_irq_enable <= 1'b0;
        end else if (irq_en_we) begin
            wdog_irq_enable <= i_sfr_wdata[`WDOG_BIT_IRQ_EN];
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            wdog_irq_priority <= 1'b0;
        end else if (irq_prio_we) begin
            wdog_irq_priority <= i_sfr_wdata[`WDOG_BIT_PRIO];
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            reset_enable <= 1'b0;
        end else if (ctl_we) begin
            reset_enable <= i_sfr_wdata[`WDOG_BIT_RESET_EN];
        end
    end

    // restart is a strobe: stored for one cycle only, reads back as zero
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            count_restart <= 1'b0;
        end else begin
            count_restart <= ctl_we && i_sfr_wdata[`WDOG_BIT_RESTART];
        end
    end

    // hardware set wins over a software clear in the same cycle
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            timeout_irq_flag <= 1'b0;
        end else if (lnk.expire) begin
            timeout_irq_flag <= 1'b1;
        end else if (o_mcu_reset) begin
            timeout_irq_flag <= 1'b0;
        end else if (ctl_we) begin
            timeout_irq_flag <= i_sfr_wdata[`WDOG_BIT_FLAG];
        end
    end

    // our reset or a software one sets it; a software one here triggers nothing
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            reset_cause_flag <= 1'b0;
        end else if (o_mcu_reset) begin
            reset_cause_flag <= 1'b1;
        end else if (ctl_we) begin
            reset_cause_flag <= i_sfr_wdata[`WDOG_BIT_CAUSE];
        end
    end

    // one-cycle request to the system reset logic
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_mcu_reset <= 1'b0;
        end else begin
            o_mcu_reset <= lnk.fire && reset_enable;
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_wdog_irq <= 1'b0;
        end else begin
            o_wdog_irq <= timeout_irq_flag && wdog_irq_enable
                && i_global_irq_enable;
        end
    end

    // upper control bits read zero; software must not rely on that
    always_comb begin
        next_rdata = 8'h00;
        next_hit = 1'b1;
        unique case (i_sfr_addr)
            `WDOG_ADDR_CLOCK_CONTROL: next_rdata = {interval_select, 3'h0, clock_mode};
            `WDOG_ADDR_CONTROL: next_rdata = {4'h0, timeout_irq_flag, reset_cause_flag,
                                              reset_enable, 1'b0};
            `WDOG_ADDR_IRQ_ENABLE: next_rdata = {3'h0, wdog_irq_enable, 4'h0};
            `WDOG_ADDR_IRQ_PRIORITY: next_rdata = {3'h0, wdog_irq_priority, 4'h0};
            default: next_hit = 1'b0;
        endcase
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_sfr_rdata <= 8'h00;
            o_sfr_hit <= 1'b0;
        end else begin
            o_sfr_rdata <= next_rdata;
            o_sfr_hit <= next_hit;
        end
    end

    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_rst);

    a_expire_flag: assert property (
        lnk.expire |=> timeout_irq_flag)
        else $error("expiry did not set the interrupt flag");
    a_reset_gate: assert property (
        o_mcu_reset |-> $past(lnk.fire) && $past(reset_enable))
        else $error("reset without window end and enable");
    a_no_reset_off: assert property (
        (lnk.fire && !reset_enable) |=> !o_mcu_reset)
        else $error("reset issued while reset disabled");
    a_cause_set: assert property (
        o_mcu_reset |=> reset_cause_flag)
        else $error("cause flag not set by watchdog reset");
    a_cause_kept: assert property (
        (!o_mcu_reset && !ctl_we) |=> $stable(reset_cause_flag))
        else $error("cause flag changed without reset or write");
    a_irq_masked: assert property (
        !wdog_irq_enable |=> !o_wdog_irq)
        else $error("interrupt raised while disabled");
    a_irq_raise: assert property (
        (lnk.expire && wdog_irq_enable && i_global_irq_enable)
        ##1 (wdog_irq_enable && i_global_irq_enable) |=> o_wdog_irq)
        else $error("expiry did not raise the interrupt");
    a_locked_ignored: assert property (
        (i_sfr_wr && i_sfr_addr == `WDOG_ADDR_CONTROL && !lnk.unlocked)
        |=> $stable(reset_enable))
        else $error("locked control write took effect");
    a_strobe_clears: assert property (
        count_restart |=> !count_restart)
        else $error("restart strobe stuck high");
    a_reset_restart: assert property (
        o_mcu_reset |-> lnk.restart ##1 !o_mcu_reset)
        else $error("watchdog reset did not restart the count");

    // register side effects, checked against the write that caused them
    a_interval_write: assert property (
        clkctl_we |=> interval_select == $past(i_sfr_wdata[7:6]))
        else $error("interval field not taken from the write");

    a_interval_kept: assert property (
        !clkctl_we |=> $stable(interval_select))
        else $error("interval field changed without a write");

    a_restart_strobe: assert property (
        (ctl_we && i_sfr_wdata[`WDOG_BIT_RESTART]) |=> count_restart)
        else $error("restart write gave no strobe");

    a_restart_no_reset: assert property (
        count_restart |=> !o_mcu_reset)
        else $error("reset issued despite restart");

    a_enable_write: assert property (
        ctl_we |=> reset_enable == $past(i_sfr_wdata[`WDOG_BIT_RESET_EN]))
        else $error("reset enable not taken from the write");

    a_flag_write: assert property (
        (ctl_we && !lnk.expire && !o_mcu_reset)
        |=> timeout_irq_flag == $past(i_sfr_wdata[`WDOG_BIT_FLAG]))
        else $error("interrupt flag not taken from the write");

    a_cause_write: assert property (
        (ctl_we && !o_mcu_reset)
        |=> reset_cause_flag == $past(i_sfr_wdata[`WDOG_BIT_CAUSE]))
        else $error("cause flag not taken from the write");

    // the count clears on expiry, so a second expiry needs a whole interval
    a_expire_single: assert property (
        lnk.expire |=> !lnk.expire)
        else $error("expiry lasted more than one cycle");

    a_irq_needs_global: assert property (
        !i_global_irq_enable |=> !o_wdog_irq)
        else $error("interrupt raised without global enable");

    a_irq_needs_flag: assert property (
        !timeout_irq_flag |=> !o_wdog_irq)
        else $error("interrupt raised without the flag");

    a_irq_en_write: assert property (
        irq_en_we |=> wdog_irq_enable == $past(i_sfr_wdata[`WDOG_BIT_IRQ_EN]))
        else $error("interrupt enable not taken from the write");

    a_prio_write: assert property (
        irq_prio_we |=> o_wdog_irq_priority == $past(i_sfr_wdata[`WDOG_BIT_PRIO]))
        else $error("priority not taken from the write");

    a_ctl_readback: assert property (
        (i_sfr_addr == `WDOG_ADDR_CONTROL)
        |=> o_sfr_hit && (o_sfr_rdata[7:4] == 4'h0) && !o_sfr_rdata[`WDOG_BIT_RESTART])
        else $error("control read shows bits that must read zero");

    a_key_hidden: assert property (
        (i_sfr_addr == `WDOG_ADDR_KEY) |=> !o_sfr_hit)
        else $error("key address answered a read");

    c_expire: cover property (lnk.expire);
    c_mcu_reset: cover property (o_mcu_reset);
    c_unlocked_write: cover property (ctl_we && i_sfr_wdata[`WDOG_BIT_RESTART]);
    c_sw_flag_irq: cover property (ctl_we && i_sfr_wdata[`WDOG_BIT_FLAG] ##2 o_wdog_irq);
endmodule : wdog_timer
`default_nettype wire

// File: wdog_unlock.sv
// Purpose: timed-access key sequencer for the control register
// Assumes: sfr_we is a one-cycle strobe per write
// Notes: the open state lasts for exactly the next write
`timescale 1ns/100ps
`default_nettype none
`include "wdog_params.svh"
module wdog_unlock (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // link to top
    wdog_link_if.key lnk
);
    wdog_pkg::wdog_key_t state;
    logic key_wr;

    assign key_wr = lnk.sfr_we && (lnk.sfr_addr == `WDOG_ADDR_KEY);
    assign lnk.unlocked = (state == wdog_pkg::WDOG_KEY_OPEN);

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            state <= wdog_pkg::WDOG_KEY_IDLE;
        end else if (lnk.sfr_we) begin
            unique case (state)
                wdog_pkg::WDOG_KEY_IDLE, wdog_pkg::WDOG_KEY_OPEN: begin
                    if (key_wr && lnk.sfr_wdata == `WDOG_KEY_FIRST) begin
                        state <= wdog_pkg::WDOG_KEY_HALF;
                    end else begin
                        state <= wdog_pkg::WDOG_KEY_IDLE;
                    end
                end
                wdog_pkg::WDOG_KEY_HALF: begin
                    if (key_wr && lnk.sfr_wdata == `WDOG_KEY_SECOND) begin
                        state <= wdog_pkg::WDOG_KEY_OPEN;
                    end else if (key_wr && lnk.sfr_wdata == `WDOG_KEY_FIRST) begin
                        state <= wdog_pkg::WDOG_KEY_HALF;
                    end else begin
                        state <= wdog_pkg::WDOG_KEY_IDLE;
                    end
                end
                default: begin
                    state <= wdog_pkg::WDOG_KEY_IDLE;
                end
            endcase
        end
    end

    a_key_opens: assert property (@(posedge i_clk) disable iff (i_rst)
        (state == wdog_pkg::WDOG_KEY_HALF && key_wr && lnk.sfr_wdata == `WDOG_KEY_SECOND)
        |=> lnk.unlocked)
        else $error("key pair did not open the lock");
    a_write_cancels: assert property (@(posedge i_clk) disable iff (i_rst)
        (lnk.sfr_we && !key_wr) |=> !lnk.unlocked)
        else $error("non-key write left the lock open");
endmodule : wdog_unlock
`default_nettype wire
